/* flow_cfg.svh */
`ifndef FLOW_CFG_SVH
`define FLOW_CFG_SVH

// ========================================
// Register map
`define AUTO_FLOW_CONFIG_ADDR 12'h0AC
`define AUTO_FLOW_CONFIG_MASK 32'h00FF_FFFF
`define AUTO_FLOW_CONFIG_RESET 24'h00_0000
`define STATUS_ADDR 12'h0B0
// ========================================
// Field positions
`define HI_MSB 23
`define HI_LSB 16
`define LO_MSB 15
`define LO_LSB 8
`define DUR_MSB 7
`define DUR_LSB 4
`define ANY_BIT 0
`define OWN_BIT 1
`define BRD_BIT 2
`define MULT_BIT 3
`define UNIT_SHIFT 6
// ========================================
// Timing: clock period in ns, jam durations in ns
`define CLK_PERIOD_NS 100
`define SLOW_EXTRA_NS 2200
`define DUR_STEP_NS 50000
`define OCC_W 14
`define DUR_CNT_W 13
`endif

/* flow_pkg.sv */
package flow_pkg;
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
    logic [3:0] dur;
    logic mult;
    logic brd;
    logic own;
    logic any;
  } flow_cfg_t;

  typedef struct packed {
    logic valid;
    logic is_mcast;
    logic is_bcast;
    logic is_own;
  } frame_start_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_PAUSED = 4'b0010,
    ST_RESUME = 4'b0100,
    ST_WAIT = 4'b1000
  } pause_state_t;
endpackage

/* jam_timer.sv */
`timescale 1ns/100ps
`include "flow_cfg.svh"
module jam_timer (
  input wire logic REF_CLK_IN,
  input wire logic RSTN_IN,
  input wire logic START_IN,
  input wire logic [3:0] DUR_IN,
  input wire logic SLOW_IN,
  output logic BUSY_OUT
);
  import flow_pkg::*;

  logic [`DUR_CNT_W-1:0] count;
  logic [`DUR_CNT_W-1:0] next_count;

  // Duration code to cycles; 10 Mb/s adds a fixed tail
  function automatic logic [`DUR_CNT_W-1:0] dur_cycles(
    input logic [3:0] code, input logic slow);
    int ns;
    ns = 0;
    case (code)
      4'h0: ns = 5000;
      4'h1: ns = 10000;
      4'h2: ns = 15000;
      4'h3: ns = 25000;
      default: ns = (int'(code) - 3) * `DUR_STEP_NS;
    endcase
    if (slow) begin
      ns = ns + `SLOW_EXTRA_NS;
    end
    return `DUR_CNT_W'(ns / `CLK_PERIOD_NS);
  endfunction

  // ========================================
  // Countdown of the jam window
  always_comb begin
    next_count = count;
    if (START_IN) begin
      next_count = dur_cycles(DUR_IN, SLOW_IN);
    end else if (count != '0) begin
      next_count = count - `DUR_CNT_W'(1);
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RSTN_IN) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign BUSY_OUT = (count != '0);
endmodule

/* host_mac_auto_flow_control.sv */
// Local design decision: the APB slave port.
`timescale 1ns/100ps
`include "flow_cfg.svh"
module host_mac_auto_flow_control (
  input wire logic REF_CLK_IN,
  input wire logic RSTN_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic [`OCC_W-1:0] RX_FIFO_USED_IN,
  input wire logic FULL_DUPLEX_IN,
  input wire logic SPEED_10_IN,
  input wire logic TX_ENABLE_IN,
  input wire logic HARDWIRED_FLOW_ENABLE_IN,
  input wire logic [15:0] PAUSE_TIME_VALUE_IN,
  input wire flow_pkg::frame_start_t FRAME_START_IN,
  input wire logic PAUSE_DONE_IN,
  output logic PAUSE_REQ_OUT,
  output logic [15:0] PAUSE_TIME_OUT,
  output logic JAM_OUT,
  output logic HARDWIRED_ABOVE_HIGH_OUT
);
  import flow_pkg::*;

  flow_cfg_t cfg;
  flow_cfg_t next_cfg;
  pause_state_t state;
  pause_state_t next_state;
  logic pause_req;
  logic next_pause_req;
  logic [15:0] pause_time;
  logic [15:0] next_pause_time;
  logic above_high;
  logic below_low;
  logic auto_en;
  logic trigger;
  logic jam_start;
  logic jam_busy;
  logic [31:0] next_prdata;
  logic [31:0] prdata;
  logic hw_above;
  logic next_hw_above;

  // ========================================
  // APB slave
  // Zero wait states keeps the bus model simple; errors flag unmapped words
  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = PSEL_IN && PENABLE_IN &&
    !(PADDR_IN == `AUTO_FLOW_CONFIG_ADDR || PADDR_IN == `STATUS_ADDR);

  // Write decode: only bits 23:0 store, upper bits ignore writes
  always_comb begin
    next_cfg = cfg;
    if (PSEL_IN && PENABLE_IN && PWRITE_IN) begin
      if (PADDR_IN == `AUTO_FLOW_CONFIG_ADDR) begin
        next_cfg = flow_cfg_t'(PWDATA_IN[23:0]);
      end
    end
  end

  // Read mux registered at setup so data stand in the access phase
  always_comb begin
    next_prdata = prdata;
    if (PSEL_IN && !PENABLE_IN && !PWRITE_IN) begin
      if (PADDR_IN == `AUTO_FLOW_CONFIG_ADDR) begin
        next_prdata = {8'h00, cfg};
      end else if (PADDR_IN == `STATUS_ADDR) begin
        next_prdata = {24'h0, state, 1'b0, jam_busy, above_high,
          pause_req};
      end else begin
        next_prdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RSTN_IN) begin
      cfg <= flow_cfg_t'(`AUTO_FLOW_CONFIG_RESET);
      prdata <= 32'h0000_0000;
    end else begin
      cfg <= next_cfg;
      prdata <= next_prdata;
    end
  end

  assign PRDATA_OUT = prdata;

  // ========================================
  // Threshold compare in bytes, evaluated every clock
  assign above_high = RX_FIFO_USED_IN >=
    (`OCC_W'(cfg.high) << `UNIT_SHIFT);
  assign below_low = RX_FIFO_USED_IN <
    (`OCC_W'(cfg.low) << `UNIT_SHIFT);
  assign auto_en = cfg.any | cfg.mult | cfg.brd | cfg.own;

  // Hard-wired flow control sees the same thresholds with hysteresis
  always_comb begin
    next_hw_above = hw_above;
    if (!HARDWIRED_FLOW_ENABLE_IN) begin
      next_hw_above = 1'b0;
    end else if (above_high) begin
      next_hw_above = 1'b1;
    end else if (below_low) begin
      next_hw_above = 1'b0;
    end
  end

  // ========================================
  // Full-duplex pause sequencer
  // One pause on crossing high, one zero pause when below low afterward
  always_comb begin
    next_state = state;
    next_pause_req = pause_req;
    next_pause_time = pause_time;
    case (state)
      ST_IDLE: begin
        // Any-frame bit alone enables full-duplex pause
        if (FULL_DUPLEX_IN && cfg.any && TX_ENABLE_IN &&
            above_high) begin
          next_pause_req = 1'b1;
          next_pause_time = PAUSE_TIME_VALUE_IN;
          next_state = ST_PAUSED;
        end
      end
      ST_PAUSED: begin
        if (!TX_ENABLE_IN) begin
          next_pause_req = 1'b0;
          next_state = ST_IDLE;
        end else if (PAUSE_DONE_IN) begin
          // Pause was sent, now wait for drain
          next_pause_req = 1'b0;
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // Stays here while above; no second pause for same episode
        if (!auto_en || !FULL_DUPLEX_IN) begin
          next_state = ST_IDLE;
        end else if (below_low && TX_ENABLE_IN) begin
          next_pause_req = 1'b1;
          next_pause_time = 16'h0000;
          next_state = ST_RESUME;
        end
      end
      ST_RESUME: begin
        if (!TX_ENABLE_IN || PAUSE_DONE_IN) begin
          next_pause_req = 1'b0;
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_pause_req = 1'b0;
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RSTN_IN) begin
      state <= ST_IDLE;
      pause_req <= 1'b0;
      pause_time <= 16'h0000;
      hw_above <= 1'b0;
    end else begin
      state <= next_state;
      pause_req <= next_pause_req;
      pause_time <= next_pause_time;
      hw_above <= next_hw_above;
    end
  end

  // Host side only; the engine MAC has its own flow control
  assign PAUSE_REQ_OUT = pause_req;
  assign PAUSE_TIME_OUT = pause_time;
  assign HARDWIRED_ABOVE_HIGH_OUT = hw_above;

  // ========================================
  // Half-duplex jam trigger
  // Any-frame overrides the per-type bits and ignores the address
  always_comb begin
    if (cfg.any) begin
      trigger = FRAME_START_IN.valid;
    end else begin
      trigger = FRAME_START_IN.valid &&
        ((cfg.mult && FRAME_START_IN.is_mcast) ||
         (cfg.brd && FRAME_START_IN.is_bcast) ||
         (cfg.own && FRAME_START_IN.is_own));
    end
  end

  // Duration only used in half duplex
  assign jam_start = !FULL_DUPLEX_IN && TX_ENABLE_IN && above_high &&
    trigger;

  jam_timer u_jam_timer (
    .REF_CLK_IN(REF_CLK_IN),
    .RSTN_IN(RSTN_IN),
    .START_IN(jam_start),
    .DUR_IN(cfg.dur),
    .SLOW_IN(SPEED_10_IN),
    .BUSY_OUT(jam_busy)
  );

  // Jam drops at once if the transmitter goes off
  assign JAM_OUT = jam_busy && TX_ENABLE_IN && !FULL_DUPLEX_IN;
endmodule

/* mac_tx_model.sv */
`timescale 1ns/100ps
// ========================================
// Host MAC transmitter: answers each pause request
module mac_tx_model (
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  input wire logic REQ_IN,
  input wire logic [3:0] DELAY_IN,
  output logic DONE_OUT
);
  logic [3:0] cnt;
  // Done pulse DELAY_IN+1 cycles after the request rises; a long delay models a busy line
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN || !REQ_IN || DONE_OUT) begin
      cnt <= 4'h0;
      DONE_OUT <= 1'b0;
    end else begin
      cnt <= cnt + 4'h1;
      DONE_OUT <= (cnt == DELAY_IN);
    end
  end
endmodule

/* host_mac_auto_flow_control_sva.sv */
`timescale 1ns/100ps
// ========================================
// Port checker
module host_mac_auto_flow_control_sva (
  input wire logic REF_CLK_IN,
  input wire logic RSTN_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  input wire logic FULL_DUPLEX_IN,
  input wire logic TX_ENABLE_IN,
  input wire flow_pkg::frame_start_t FRAME_START_IN,
  input wire logic PAUSE_DONE_IN,
  input wire logic PAUSE_REQ_OUT,
  input wire logic [15:0] PAUSE_TIME_OUT,
  input wire logic JAM_OUT
);
  import flow_pkg::*;
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!RSTN_IN);
  logic acc;
  logic req;
  // Access phase and pending pause shorthands
  assign acc = PSEL_IN && PENABLE_IN;
  assign req = PAUSE_REQ_OUT;
  property p_err;
    acc && PADDR_IN != 12'h0AC && PADDR_IN != 12'h0B0 |-> PSLVERR_OUT;
  endproperty
  a_err: assert property (p_err) else $error("no error on hole");
  property p_ok;
    acc && PADDR_IN == 12'h0AC |-> PREADY_OUT && !PSLVERR_OUT;
  endproperty
  a_ok: assert property (p_ok) else $error("config access refused");
  property p_txoff;
    !TX_ENABLE_IN [*2] |-> !req;
  endproperty
  a_txoff: assert property (p_txoff) else $error("pause with tx off");
  property p_jamtx;
    $rose(JAM_OUT) |-> $past(TX_ENABLE_IN);
  endproperty
  a_jamtx: assert property (p_jamtx) else $error("jam with tx off");
  property p_rise;
    $rose(req) |-> $past(FULL_DUPLEX_IN);
  endproperty
  a_rise: assert property (p_rise) else $error("pause in half");
  property p_hold;
    req && !PAUSE_DONE_IN && TX_ENABLE_IN |=> req;
  endproperty
  a_hold: assert property (p_hold) else $error("pause dropped");
  property p_drop;
    req && PAUSE_DONE_IN |=> !req;
  endproperty
  a_drop: assert property (p_drop) else $error("pause repeated");
  property p_time;
    req && $past(req) |-> $stable(PAUSE_TIME_OUT);
  endproperty
  a_time: assert property (p_time) else $error("pause time moved");
  property p_jam;
    $rose(JAM_OUT) |-> $past(!FULL_DUPLEX_IN && FRAME_START_IN.valid);
  endproperty
  a_jam: assert property (p_jam) else $error("jam without frame");
  c_zero: cover property ($rose(req) && PAUSE_TIME_OUT == 16'h0000);
  c_jam: cover property ($rose(JAM_OUT));
  c_err: cover property (acc && PSLVERR_OUT);
endmodule
bind host_mac_auto_flow_control host_mac_auto_flow_control_sva chk (
  .REF_CLK_IN(REF_CLK_IN), .RSTN_IN(RSTN_IN), .PSEL_IN(PSEL_IN),
  .PENABLE_IN(PENABLE_IN), .PADDR_IN(PADDR_IN), .PREADY_OUT(PREADY_OUT),
  .PSLVERR_OUT(PSLVERR_OUT), .FULL_DUPLEX_IN(FULL_DUPLEX_IN),
  .TX_ENABLE_IN(TX_ENABLE_IN), .FRAME_START_IN(FRAME_START_IN),
  .PAUSE_DONE_IN(PAUSE_DONE_IN), .PAUSE_REQ_OUT(PAUSE_REQ_OUT),
  .PAUSE_TIME_OUT(PAUSE_TIME_OUT), .JAM_OUT(JAM_OUT));

/* host_mac_auto_flow_control_tb.sv */
`timescale 1ns/100ps
module host_mac_auto_flow_control_tb;
  import flow_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, fd = 1'b1, s10 = 1'b0;
  logic txen = 1'b1, hwen = 1'b1, pready, pslverr, done, req, jam, hwhi;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic sl;
  logic [13:0] used = 14'h0000;
  logic [15:0] ptv = 16'h1234, ptime;
  logic [3:0] dly = 4'h1;
  frame_start_t fs = '0;
  int err_count = 0, checks_done = 0, n, c;
  // ========================================
  // Clock, design and transmitter model
  always #50 clk = ~clk;
  host_mac_auto_flow_control uut (.REF_CLK_IN(clk), .RSTN_IN(rstn),
    .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .RX_FIFO_USED_IN(used), .FULL_DUPLEX_IN(fd),
    .SPEED_10_IN(s10), .TX_ENABLE_IN(txen),
    .HARDWIRED_FLOW_ENABLE_IN(hwen), .PAUSE_TIME_VALUE_IN(ptv),
    .FRAME_START_IN(fs), .PAUSE_DONE_IN(done), .PAUSE_REQ_OUT(req),
    .PAUSE_TIME_OUT(ptime), .JAM_OUT(jam), .HARDWIRED_ABOVE_HIGH_OUT(hwhi));
  mac_tx_model mac (.CLK_IN(clk), .RSTN_IN(rstn), .REQ_IN(req),
    .DELAY_IN(dly), .DONE_OUT(done));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("checks=%0d errors=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic tmo;
    err_count++;
    final_report();
  endtask
  // APB transfer; read data lands in rd
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 8);
    rd = prdata;
    sl = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (k == 8) tmo();
  endtask
  task automatic wait_req(input logic v);
    int k;
    for (k = 0; k < 50 && req !== v; k++) @(posedge clk);
    if (req !== v) tmo();
  endtask
  // Frame start pulse, then count jam cycles into n
  task automatic jam_len(input logic [3:0] f);
    @(posedge clk);
    fs <= frame_start_t'(f);
    @(posedge clk);
    fs <= '0;
    n = 0;
    #1;
    while (jam === 1'b1 && n < 7000) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  // Jam length in clocks for a code; the slow link adds 2.2 us
  function automatic int dur(input int code, input logic slow);
    return ((code < 4) ? 50 * (code + 1 + (code == 3)) : 500 * (code - 3))
      + (slow ? 22 : 0);
  endfunction
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, 12'h0AC, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 12'h0AC, 32'hFFFF_FFFF);
    apb(1'b0, 12'h0AC, 32'h0);
    chk(rd, 32'h00FF_FFFF);
    chk(32'(sl), 32'h0);
    apb(1'b0, 12'h100, 32'h0);
    chk(rd, 32'h0);
    chk(32'(sl), 32'h1);
    apb(1'b1, 12'h0AC, 32'h0002_0101);
    used <= 14'h007F;
    repeat (5) @(posedge clk);
    chk(32'(req), 32'h0);
    chk(32'(hwhi), 32'h0);
    used <= 14'h0080;
    repeat (2) @(posedge clk);
    chk(32'(req), 32'h1);
    chk(32'(ptime), 32'h1234);
    wait_req(1'b0);
    repeat (20) @(posedge clk);
    chk(32'(req), 32'h0);
    chk(32'(hwhi), 32'h1);
    apb(1'b0, 12'h0B0, 32'h0);
    chk(rd, 32'h0000_0082);
    used <= 14'h0040;
    repeat (5) @(posedge clk);
    chk(32'(req), 32'h0);
    used <= 14'h003F;
    wait_req(1'b1);
    chk(32'(ptime), 32'h0);
    chk(32'(hwhi), 32'h0);
    wait_req(1'b0);
    repeat (10) @(posedge clk);
    chk(32'(req), 32'h0);
    dly <= 4'hC;
    txen <= 1'b0;
    used <= 14'h0100;
    repeat (10) @(posedge clk);
    chk(32'(req), 32'h0);
    txen <= 1'b1;
    wait_req(1'b1);
    chk(32'(ptime), 32'h1234);
    used <= 14'h0000;
    wait_req(1'b0);
    wait_req(1'b1);
    chk(32'(ptime), 32'h0);
    wait_req(1'b0);
    fd <= 1'b0;
    dly <= 4'h1;
    used <= 14'h0100;
    apb(1'b1, 12'h0AC, 32'h0002_0108);
    jam_len(4'hA);
    chk(n, 32'h0);
    jam_len(4'hC);
    chk(n, dur(0, 1'b0));
    chk(32'(req), 32'h0);
    // Any-frame trigger with every duration code
    for (c = 0; c < 16; c++) begin
      apb(1'b1, 12'h0AC, {24'h000201, c[3:0], 4'h1});
      jam_len(4'h8);
      chk(n, dur(c, 1'b0));
    end
    s10 <= 1'b1;
    jam_len(4'h8);
    chk(n, dur(15, 1'b1));
    final_report();
  end
endmodule
